// ==== verilog/event_bank_pkg.sv ====
package event_bank_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [7:0] FAULT_FLAGS_ADDR   = 8'h04;
    localparam logic [7:0] MEAS_FLAGS_ADDR    = 8'h05;
    localparam logic [7:0] TIMER_FLAGS_ADDR   = 8'h06;
    localparam logic [7:0] CHARGE_MASK_ADDR   = 8'h07;

    // reset values
    localparam logic [7:0] FLAGS_RESET        = 8'h00;
    localparam logic [7:0] MASK_RESET         = 8'h00;
    localparam logic [7:0] UNMAPPED_READ      = 8'h00;

    // bits that can ever be set; reserved bits read zero
    localparam logic [7:0] FAULT_LIVE_BITS    = 8'hbf;
    localparam logic [7:0] MEAS_LIVE_BITS     = 8'hf1;
    localparam logic [7:0] TIMER_LIVE_BITS    = 8'h7f;

    // fault event register bit positions
    localparam int unsigned FLT_OVERVOLT_BIT  = 7;
    localparam int unsigned FLT_BAT_OCP_BIT   = 5;
    localparam int unsigned FLT_BAT_UV_BIT    = 4;
    localparam int unsigned FLT_COLD_BIT      = 3;
    localparam int unsigned FLT_COOL_BIT      = 2;
    localparam int unsigned FLT_WARM_BIT      = 1;
    localparam int unsigned FLT_HOT_BIT       = 0;

    // measurement event register bit positions
    localparam int unsigned MEAS_DONE_BIT     = 7;
    localparam int unsigned MEAS_CMP1_BIT     = 6;
    localparam int unsigned MEAS_CMP2_BIT     = 5;
    localparam int unsigned MEAS_CMP3_BIT     = 4;
    localparam int unsigned MEAS_TS_OPEN_BIT  = 0;

    // timer and protection event register bit positions
    localparam int unsigned TMR_WATCHDOG_BIT  = 6;
    localparam int unsigned TMR_SAFETY_BIT    = 5;
    localparam int unsigned TMR_REG_OCP_BIT   = 4;
    localparam int unsigned TMR_ISET_OPEN_BIT = 3;
    localparam int unsigned TMR_WAKE1_BIT     = 2;
    localparam int unsigned TMR_WAKE2_BIT     = 1;
    localparam int unsigned TMR_RST_WARN_BIT  = 0;

    // interrupt mask register bit positions
    localparam int unsigned MSK_CV_BIT        = 6;
    localparam int unsigned MSK_DONE_BIT      = 5;
    localparam int unsigned MSK_ILIM_BIT      = 4;
    localparam int unsigned MSK_PRIO_BIT      = 3;
    localparam int unsigned MSK_DROOP_BIT     = 2;
    localparam int unsigned MSK_HEAT_BIT      = 1;
    localparam int unsigned MSK_PGOOD_BIT     = 0;

    // number of comparators
    localparam int unsigned NUM_CMP           = 3;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr_en;
        logic              rd_en;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    // fault and thermistor region events, one-cycle pulses
    typedef struct packed {
        logic input_overvoltage_event;
        logic battery_overcurrent_event;
        logic battery_undervoltage_event;
        logic thermistor_cold_entry;
        logic thermistor_cool_entry;
        logic thermistor_warm_entry;
        logic thermistor_hot_entry;
    } fault_events_s;

    // converter events; comparator inputs are levels
    typedef struct packed {
        logic               conversion_done;
        logic [NUM_CMP-1:0] measurement_above;
        logic [NUM_CMP-1:0] threshold_direction;
        logic               thermistor_open_event;
    } meas_events_s;

    // timer and protection events, one-cycle pulses
    typedef struct packed {
        logic host_watchdog_expiry;
        logic charge_timer_expiry;
        logic regulator_overcurrent_event;
        logic current_set_open_event;
        logic button_wake_one_expiry;
        logic button_wake_two_expiry;
        logic button_reset_warning;
    } timer_events_s;

    // charge-state events, one-cycle pulses; power good is a level
    typedef struct packed {
        logic constant_voltage_entry;
        logic charge_done;
        logic input_limit_active;
        logic supply_priority_active;
        logic input_droop_active;
        logic die_heat_active;
        logic input_power_good;
    } charge_events_s;

endpackage

// ==== verilog/sticky_flag_reg.sv ====
`timescale 1ns/10ps
module sticky_flag_reg #(
    parameter int unsigned        WIDTH     = 8,
    parameter logic [WIDTH-1:0]   LIVE_MASK = '1,
    parameter logic [WIDTH-1:0]   RST_VAL   = '0
) (
    input  wire logic             clk,        // core clock
    input  wire logic             srst,       // sync reset, high
    input  wire logic [WIDTH-1:0] set_pulse,  // event pulses
    input  wire logic             clear,      // read of this register
    output logic      [WIDTH-1:0] flags       // current flag state
);
    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // set wins over clear so an event during a read waits for the next read
    always_comb begin
        flags_nxt = clear ? '0 : flags_r;
        flags_nxt = (flags_nxt | set_pulse) & LIVE_MASK;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= RST_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;
endmodule

// ==== verilog/event_flag_mask_bank.sv ====
`timescale 1ns/10ps
// Summary of operation
// - fault event register at 0x4, resets zero, cleared by a read of 0x4
// - bit 7 latches on input overvoltage; bit 6 reserved reads zero
// - bit 5 latches on battery overcurrent
// - bit 4 reports battery undervoltage; printed polarity looks inverted
// - bits 3..0 latch on cold, cool, warm, hot region entry
// - measurement event register at 0x5, resets zero, cleared by read
// - bit 7 latches when a conversion completes
// - bits 6..4 latch when comparator 1..3 crosses in its chosen direction
// - bits 3..1 reserved read zero; bit 0 latches on thermistor open
// - timer event register at 0x6, resets zero, cleared by read, bit 7 reserved
// - bit 6 latches on host watchdog expiry
// - bit 5 latches on charging safety timer expiry
// - bit 4 latches on output regulator overcurrent
// - bit 3 latches on current-setting pin open
// - bits 2 and 1 latch on button wake timer one and two expiry
// - bit 0 latches on button reset-warning timer expiry
// - read-write interrupt mask at 0x7, resets zero, all unmasked
// - a mask bit of one blocks its interrupt, zero allows it
// - mask bits: cv, done, input limit, priority, droop, heat, power good
// - power-good event fires on any change of power-good status
module event_flag_mask_bank
    import event_bank_pkg::*;
(
    input  wire logic                           clk,             // core clock, 200 MHz
    input  wire logic                           srst,            // sync reset, high
    input  wire event_bank_pkg::reg_req_s       reg_req,         // register port request
    output logic      [event_bank_pkg::DATA_W-1:0] reg_rdata,    // read data, one cycle after read
    output logic                                reg_rvalid,      // read data valid pulse
    input  wire event_bank_pkg::fault_events_s  fault_ev,        // fault and region events
    input  wire event_bank_pkg::meas_events_s   meas_ev,         // converter events
    input  wire event_bank_pkg::timer_events_s  timer_ev,        // timer and protection events
    input  wire event_bank_pkg::charge_events_s charge_ev,       // charge-state events
    output logic      [7:0]                     charge_irq_req,  // unmasked charge-state requests
    output logic      [7:0]                     mask_bits,       // current interrupt mask
    output logic                                fault_pending,   // fault register non-zero
    output logic                                meas_pending,    // measurement register non-zero
    output logic                                timer_pending    // timer register non-zero
);
    import event_bank_pkg::*;

    // register decode, used for every register
    // the full offset is compared, so nothing aliases onto the four registers
    function automatic logic hit(input reg_req_s req, input logic [7:0] a);
        hit = (req.addr == a);
    endfunction

    logic rd_fault;
    logic rd_meas;
    logic rd_timer;
    logic wr_mask;

    // read and write strobes per register
    // a read and a write may come together; each is decoded on its own
    always_comb begin
        rd_fault = reg_req.rd_en & hit(reg_req, FAULT_FLAGS_ADDR);
        rd_meas  = reg_req.rd_en & hit(reg_req, MEAS_FLAGS_ADDR);
        rd_timer = reg_req.rd_en & hit(reg_req, TIMER_FLAGS_ADDR);
        wr_mask  = reg_req.wr_en & hit(reg_req, CHARGE_MASK_ADDR);
    end

    // comparator crossings and power-good history
    logic [NUM_CMP-1:0] cmp_cross;
    logic               pgood_r;
    logic               pgood_nxt;
    logic               pgood_change;

    // one crossing detector per comparator; a level held high flags only once
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
        logic meet;
        logic meet_r;
        logic meet_nxt;

        // condition met = above when direction is one, below when zero
        always_comb begin
            meet     = ~(meas_ev.measurement_above[i] ^ meas_ev.threshold_direction[i]);
            meet_nxt = meet;
        end

        // history starts cleared so a condition already true at reset counts once
        always_ff @(posedge clk) begin
            if (srst) begin
                meet_r <= 1'b0;
            end else begin
                meet_r <= meet_nxt;
            end
        end

        // rising edge only; flipping the direction bit can also produce one
        assign cmp_cross[i] = meet & ~meet_r;
    end

    // power-good change in either direction
    always_comb begin
        pgood_nxt    = charge_ev.input_power_good;
        pgood_change = charge_ev.input_power_good ^ pgood_r;
    end

    // history starts low, so a supply already good at reset reports one change
    always_ff @(posedge clk) begin
        if (srst) begin
            pgood_r <= 1'b0;
        end else begin
            pgood_r <= pgood_nxt;
        end
    end

    // map event pulses onto register bit positions
    logic [7:0] fault_set;
    logic [7:0] meas_set;
    logic [7:0] timer_set;

    always_comb begin
        // fault register: bit 6 is reserved and never set
        fault_set = 8'h00;
        fault_set[FLT_OVERVOLT_BIT]  = fault_ev.input_overvoltage_event;
        fault_set[FLT_BAT_OCP_BIT]   = fault_ev.battery_overcurrent_event;
        // one means undervoltage seen, keeping the zero reset meaningful
        fault_set[FLT_BAT_UV_BIT]    = fault_ev.battery_undervoltage_event;
        fault_set[FLT_COLD_BIT]      = fault_ev.thermistor_cold_entry;
        fault_set[FLT_COOL_BIT]      = fault_ev.thermistor_cool_entry;
        fault_set[FLT_WARM_BIT]      = fault_ev.thermistor_warm_entry;
        fault_set[FLT_HOT_BIT]       = fault_ev.thermistor_hot_entry;

        // comparator bits come from the crossing detectors, not the raw levels
        meas_set = 8'h00;
        meas_set[MEAS_DONE_BIT]      = meas_ev.conversion_done;
        meas_set[MEAS_CMP1_BIT]      = cmp_cross[0];
        meas_set[MEAS_CMP2_BIT]      = cmp_cross[1];
        meas_set[MEAS_CMP3_BIT]      = cmp_cross[2];
        meas_set[MEAS_TS_OPEN_BIT]   = meas_ev.thermistor_open_event;

        // timer register: bit 7 is reserved and never set
        timer_set = 8'h00;
        timer_set[TMR_WATCHDOG_BIT]  = timer_ev.host_watchdog_expiry;
        timer_set[TMR_SAFETY_BIT]    = timer_ev.charge_timer_expiry;
        timer_set[TMR_REG_OCP_BIT]   = timer_ev.regulator_overcurrent_event;
        timer_set[TMR_ISET_OPEN_BIT] = timer_ev.current_set_open_event;
        timer_set[TMR_WAKE1_BIT]     = timer_ev.button_wake_one_expiry;
        timer_set[TMR_WAKE2_BIT]     = timer_ev.button_wake_two_expiry;
        timer_set[TMR_RST_WARN_BIT]  = timer_ev.button_reset_warning;
    end

    logic [7:0] fault_flags;
    logic [7:0] meas_flags;
    logic [7:0] timer_flags;

    // clear-on-read flag registers; reserved bits masked to zero
    sticky_flag_reg #(
        .WIDTH     (8),
        .LIVE_MASK (FAULT_LIVE_BITS),
        .RST_VAL   (FLAGS_RESET)
    ) u_fault_flags (
        .clk       (clk),
        .srst      (srst),
        .set_pulse (fault_set),
        .clear     (rd_fault),
        .flags     (fault_flags)
    );

    // measurement flags; reserved bits 3..1 stay zero
    sticky_flag_reg #(
        .WIDTH     (8),
        .LIVE_MASK (MEAS_LIVE_BITS),
        .RST_VAL   (FLAGS_RESET)
    ) u_meas_flags (
        .clk       (clk),
        .srst      (srst),
        .set_pulse (meas_set),
        .clear     (rd_meas),
        .flags     (meas_flags)
    );

    // timer and protection flags; reserved bit 7 stays zero
    sticky_flag_reg #(
        .WIDTH     (8),
        .LIVE_MASK (TIMER_LIVE_BITS),
        .RST_VAL   (FLAGS_RESET)
    ) u_timer_flags (
        .clk       (clk),
        .srst      (srst),
        .set_pulse (timer_set),
        .clear     (rd_timer),
        .flags     (timer_flags)
    );

    // interrupt mask, all eight bits writable including reserved bit 7
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;

    // writes to the flag registers are ignored; they only clear on read
    always_comb begin
        mask_nxt = wr_mask ? reg_req.wdata : mask_r;
    end

    // mask register, all unmasked after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_r <= MASK_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // charge-state requests; masking never touches the flags themselves
    logic [7:0] charge_raw;
    logic [7:0] irq_req_r;
    logic [7:0] irq_req_nxt;

    always_comb begin
        // bit 7 has no event behind it, so its request stays low
        charge_raw = 8'h00;
        charge_raw[MSK_CV_BIT]    = charge_ev.constant_voltage_entry;
        charge_raw[MSK_DONE_BIT]  = charge_ev.charge_done;
        charge_raw[MSK_ILIM_BIT]  = charge_ev.input_limit_active;
        charge_raw[MSK_PRIO_BIT]  = charge_ev.supply_priority_active;
        charge_raw[MSK_DROOP_BIT] = charge_ev.input_droop_active;
        charge_raw[MSK_HEAT_BIT]  = charge_ev.die_heat_active;
        charge_raw[MSK_PGOOD_BIT] = pgood_change;
        // a set mask bit blocks its request; zero lets it through
        irq_req_nxt = charge_raw & ~mask_r;
    end

    // requests registered so the pulse leaves the block glitch free
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_req_r <= 8'h00;
        end else begin
            irq_req_r <= irq_req_nxt;
        end
    end

    // read mux; the value returned is the one before the clear takes effect
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic       rvalid_r;
    logic       rvalid_nxt;

    always_comb begin
        rdata_nxt  = rdata_r;
        // every read is answered, mapped or not
        rvalid_nxt = reg_req.rd_en;
        // unmapped offsets answer zero and clear nothing
        if (reg_req.rd_en) begin
            if (hit(reg_req, FAULT_FLAGS_ADDR)) begin
                rdata_nxt = fault_flags;
            end else if (hit(reg_req, MEAS_FLAGS_ADDR)) begin
                rdata_nxt = meas_flags;
            end else if (hit(reg_req, TIMER_FLAGS_ADDR)) begin
                rdata_nxt = timer_flags;
            end else if (hit(reg_req, CHARGE_MASK_ADDR)) begin
                rdata_nxt = mask_r;
            end else begin
                rdata_nxt = UNMAPPED_READ;
            end
        end
    end

    // answer registered one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // pending levels come from flops fed by the next flag values, so they
    // track the flags cycle for cycle; this repeats the flag update, so a
    // change to the flag register must be mirrored here
    logic [2:0] pending_r;
    logic [2:0] pending_nxt;

    always_comb begin
        pending_nxt[0] = |(((rd_fault ? 8'h00 : fault_flags) | fault_set) & FAULT_LIVE_BITS);
        pending_nxt[1] = |(((rd_meas ? 8'h00 : meas_flags) | meas_set) & MEAS_LIVE_BITS);
        pending_nxt[2] = |(((rd_timer ? 8'h00 : timer_flags) | timer_set) & TIMER_LIVE_BITS);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pending_r <= 3'h0;
        end else begin
            pending_r <= pending_nxt;
        end
    end

    // register port answer
    assign reg_rdata      = rdata_r;
    assign reg_rvalid     = rvalid_r;

    // interrupt request, mask and pending levels
    assign charge_irq_req = irq_req_r;
    assign mask_bits      = mask_r;
    assign fault_pending  = pending_r[0];
    assign meas_pending   = pending_r[1];
    assign timer_pending  = pending_r[2];
endmodule

// ==== verification/event_bank_asserts.sv ====
`timescale 1ns/10ps
module event_bank_asserts
    import event_bank_pkg::*;
(
    input wire logic                              clk,            // core clock
    input wire logic                              srst,           // sync reset
    input wire event_bank_pkg::reg_req_s          reg_req,        // register request
    input wire logic [event_bank_pkg::DATA_W-1:0] reg_rdata,      // read data
    input wire logic                              reg_rvalid,     // read answer
    input wire event_bank_pkg::fault_events_s     fault_ev,       // fault events
    input wire event_bank_pkg::meas_events_s      meas_ev,        // converter events
    input wire event_bank_pkg::timer_events_s     timer_ev,       // timer events
    input wire event_bank_pkg::charge_events_s    charge_ev,      // charge events
    input wire logic [7:0]                        charge_irq_req, // masked requests
    input wire logic [7:0]                        mask_bits,      // mask content
    input wire logic                              fault_pending,  // fault non-zero
    input wire logic                              meas_pending,   // meas non-zero
    input wire logic                              timer_pending   // timer non-zero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // a write in the same cycle makes the mask ambiguous, so it is left out
    logic wr_mask;
    assign wr_mask = reg_req.wr_en && reg_req.addr == CHARGE_MASK_ADDR;

    sequence s_rd(a);
        reg_req.rd_en && reg_req.addr == a;
    endsequence
    sequence s_quiet_fault_read;
        s_rd(FAULT_FLAGS_ADDR) ##0 (fault_ev == '0);
    endsequence

    a_read_answer: assert property (reg_req.rd_en |=> reg_rvalid)
        else $error("read without answer");
    a_rvalid_pulse: assert property (!reg_req.rd_en |=> !reg_rvalid)
        else $error("answer without read");
    a_fault_clear: assert property (s_quiet_fault_read |=> !fault_pending)
        else $error("fault flags survive read");
    a_fault_sets: assert property ((fault_ev != '0) |=> fault_pending)
        else $error("fault event lost");
    a_fault_holds: assert property (fault_pending && !reg_req.rd_en |=> fault_pending)
        else $error("fault flag dropped unread");
    a_meas_sets: assert property (meas_ev.conversion_done || meas_ev.thermistor_open_event
        |=> meas_pending)
        else $error("meas event lost");
    a_timer_sets: assert property ((timer_ev != '0) |=> timer_pending)
        else $error("timer event lost");
    a_mask_write: assert property (wr_mask |=> mask_bits == $past(reg_req.wdata))
        else $error("mask write lost");
    a_mask_hold: assert property (!wr_mask |=> $stable(mask_bits))
        else $error("mask changed without write");
    a_irq_pass: assert property (charge_ev.constant_voltage_entry && !mask_bits[MSK_CV_BIT]
        && !wr_mask |=> charge_irq_req[MSK_CV_BIT])
        else $error("unmasked request missing");
    a_pgood_change: assert property (!$past(srst) && $changed(charge_ev.input_power_good)
        && !mask_bits[MSK_PGOOD_BIT] |=> charge_irq_req[MSK_PGOOD_BIT])
        else $error("power-good change lost");
    a_irq_block: assert property (!wr_mask |=> (charge_irq_req & $past(mask_bits)) == 8'h00)
        else $error("masked request passed");
    a_unmapped_zero: assert property (reg_req.rd_en && (reg_req.addr < 8'h04 || reg_req.addr > 8'h07)
        |=> reg_rdata == UNMAPPED_READ)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_req.rd_en |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule

bind event_flag_mask_bank event_bank_asserts chk (.clk(clk), .srst(srst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_ev(fault_ev), .meas_ev(meas_ev),
    .timer_ev(timer_ev), .charge_ev(charge_ev), .charge_irq_req(charge_irq_req), .mask_bits(mask_bits),
    .fault_pending(fault_pending), .meas_pending(meas_pending), .timer_pending(timer_pending));

// ==== verification/event_flag_mask_bank_tb.sv ====
`timescale 1ns/10ps
module event_flag_mask_bank_tb;
    import event_bank_pkg::*;
    logic           clk;
    logic           srst;
    reg_req_s       req, s_req;
    fault_events_s  fev, s_fev;
    meas_events_s   mev, s_mev;
    timer_events_s  tev, s_tev;
    charge_events_s cev, s_cev;
    logic [7:0]     rdata, irq, mask;
    logic           rvalid, fp, mp, tp, m_pg;
    logic [7:0]     m_flt, m_meas, m_tmr, m_mask, m_irq;
    logic [2:0]     m_cond;
    logic [7:0]     exp_q[$];
    int             error_cnt = 0;
    int             samples_checked = 0;

    event_flag_mask_bank uut (.clk(clk), .srst(srst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .fault_ev(fev), .meas_ev(mev), .timer_ev(tev), .charge_ev(cev), .charge_irq_req(irq),
        .mask_bits(mask), .fault_pending(fp), .meas_pending(mp), .timer_pending(tp));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // staged values go out once per step, so no input is assigned twice at one time
    task automatic apply;
        req = s_req;
        fev = s_fev;
        mev = s_mev;
        tev = s_tev;
        cev = s_cev;
        s_req.rd_en = 1'b0;
        s_req.wr_en = 1'b0;
        s_fev = '0;
        s_tev = '0;
        s_cev[6:1] = 6'h00;
        s_mev.conversion_done = 1'b0;
        s_mev.thermistor_open_event = 1'b0;
    endtask

    task automatic nx;
        @(posedge clk);
        #1;
        apply;
    endtask

    task automatic rd(input logic [7:0] a);
        s_req.rd_en = 1'b1;
        s_req.addr = a;
    endtask

    // reference model; outputs seen here are those of the previous edge
    always @(posedge clk) begin : model
        logic [7:0] em;
        logic [2:0] cnd;
        if (!srst) begin
            check(fp, |m_flt);
            check(mp, |m_meas);
            check(tp, |m_tmr);
            check(mask, m_mask);
            check(irq, m_irq);
        end
        cnd = ~(mev.measurement_above ^ mev.threshold_direction);
        em = {mev.conversion_done, cnd[0] & ~m_cond[0], cnd[1] & ~m_cond[1], cnd[2] & ~m_cond[2], 3'h0,
              mev.thermistor_open_event};
        if (srst) begin
            {m_flt, m_meas, m_tmr, m_mask, m_irq} = '0;
            m_cond = 3'h0;
            m_pg = 1'b0;
            exp_q.delete();
        end else begin
            if (req.rd_en) begin
                exp_q.push_back(req.addr == FAULT_FLAGS_ADDR ? m_flt : req.addr == MEAS_FLAGS_ADDR ? m_meas :
                                req.addr == TIMER_FLAGS_ADDR ? m_tmr : req.addr == CHARGE_MASK_ADDR ? m_mask : 8'h00);
                if (req.addr == FAULT_FLAGS_ADDR) m_flt = 8'h00;
                if (req.addr == MEAS_FLAGS_ADDR) m_meas = 8'h00;
                if (req.addr == TIMER_FLAGS_ADDR) m_tmr = 8'h00;
            end
            m_irq = {1'b0, cev[6:1] & ~m_mask[6:1], (cev.input_power_good ^ m_pg) & ~m_mask[0]};
            if (req.wr_en && req.addr == CHARGE_MASK_ADDR) m_mask = req.wdata;
            m_flt = m_flt | {fev[6], 1'b0, fev[5:0]};
            m_meas = m_meas | em;
            m_tmr = m_tmr | {1'b0, tev};
            m_cond = cnd;
            m_pg = cev.input_power_good;
        end
    end

    // read answers against the oldest note
    always @(posedge clk) begin
        if (!srst && rvalid === 1'b1) begin
            check(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        end_sim;
    end

    initial begin
        int r;
        {s_req, s_fev, s_tev, s_cev, s_mev} = '0;
        s_mev.threshold_direction = 3'h7; // no crossing pending at release
        apply;
        srst = 1'b1;
        r = $urandom(23);
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        // reset values and unmapped neighbours, back to back
        for (int a = 3; a <= 8; a++) begin
            rd(8'(a));
            nx;
        end
        // each fault and timer event bit alone, then its register read
        for (int i = 0; i < 7; i++) begin
            s_fev = 7'h01 << i;
            s_tev = 7'h01 << i;
            s_cev[6:1] = 6'h01 << i;
            nx;
            rd(FAULT_FLAGS_ADDR);
            nx;
            rd(TIMER_FLAGS_ADDR);
            nx;
        end
        // event arriving with the clearing read
        s_fev = 7'h7f;
        rd(FAULT_FLAGS_ADDR);
        nx;
        rd(FAULT_FLAGS_ADDR);
        nx;
        // random traffic with a reset in mid-run
        for (int n = 0; n < 3000; n++) begin
            r = $urandom % 8;
            if (r == 0) rd(8'h03 + 8'($urandom % 6));
            if (r == 1) begin
                s_req.wr_en = 1'b1;
                s_req.addr = 8'h03 + 8'($urandom % 6);
                s_req.wdata = 8'($urandom);
            end
            if ($urandom % 16 == 0) s_fev = 7'($urandom);
            if ($urandom % 16 == 0) s_tev = 7'($urandom);
            if ($urandom % 4 == 0) s_cev[6:1] = 6'($urandom);
            if ($urandom % 8 == 0) s_cev.input_power_good = ~s_cev.input_power_good;
            s_mev.conversion_done = ($urandom % 16 == 0);
            s_mev.thermistor_open_event = ($urandom % 16 == 0);
            if ($urandom % 8 == 0) s_mev.measurement_above = 3'($urandom);
            if ($urandom % 32 == 0) s_mev.threshold_direction = 3'($urandom);
            if (n == 1500) srst = 1'b1;
            if (n == 1503) srst = 1'b0;
            nx;
        end
        repeat (3) nx;
        check(8'(exp_q.size()), 8'h00);
        end_sim;
    end
endmodule
